// ---- logic/sie_engine.sv ----
// String instruction engine with its element FIFO and APB register file.
// Assumes a memory that answers each request with a one-cycle mem_ack, read data in the low bits.
`timescale 1ns/1ps
`include "sie_params.svh"

module sie_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sie_fifo

module sie_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output sie_pkg::sie_mem_req_type mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic busy
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CHECK = 4'b0001,
        ST_READ1 = 4'b0010,
        ST_XLATE = 4'b0011,
        ST_TEST = 4'b0100,
        ST_PUSH = 4'b0101,
        ST_POP = 4'b0110,
        ST_WRITE2 = 4'b0111,
        ST_READ2 = 4'b1000,
        ST_STEP = 4'b1001
    } sie_state_type;

    sie_state_type state_q;
    logic [31:0] limit_q;
    logic [31:0] str1_q;
    logic [31:0] str2_q;
    logic [31:0] table_q;
    logic [31:0] cmpval_q;
    sie_pkg::sie_op_type op_q;
    sie_pkg::sie_size_type size_q;
    sie_pkg::sie_end_type why_q;
    logic xlt_q;
    logic back_q;
    logic until_q;
    logic while_q;
    logic done_q;
    logic [31:0] elem_q;
    logic [31:0] cur_q;
    sie_pkg::sie_mem_req_type req_q;
    logic [31:0] step;
    logic [31:0] elem_mask;
    logic [31:0] rd_elem;
    logic wr_acc;
    logic rd_acc;
    logic start;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;
    logic stop_match;

    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign start = wr_acc && paddr == `SIE_OFS_CTRL && pwdata[`SIE_CTRL_START] && state_q == ST_IDLE;
    assign busy = state_q != ST_IDLE;
    assign mem_req = req_q;

    // Element size and mask follow the size field
    always_comb begin
        case (size_q)
            sie_pkg::SIE_SZ_BYTE: elem_mask = 32'h0000_00ff;
            sie_pkg::SIE_SZ_WORD: elem_mask = 32'h0000_ffff;
            default: elem_mask = 32'hffff_ffff;
        endcase
        step = 32'h0000_0001 << size_q;
        rd_elem = mem_rdata & elem_mask;
    end

    // Until has priority when both test options are set
    assign stop_match = until_q ? (elem_q == (cmpval_q & elem_mask)) // [R4]
        : (while_q && elem_q != (cmpval_q & elem_mask)); // [R5]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
            prdata <= `SIE_REG_RESET;
        end else begin
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= paddr > `SIE_OFS_STATUS || paddr[1:0] != 2'b00;
            end
            if (rd_acc) begin
                case (paddr)
                    `SIE_OFS_LIMIT: prdata <= limit_q;
                    `SIE_OFS_STR1: prdata <= str1_q;
                    `SIE_OFS_STR2: prdata <= str2_q;
                    `SIE_OFS_TABLE: prdata <= table_q;
                    `SIE_OFS_CMPVAL: prdata <= cmpval_q;
                    `SIE_OFS_CTRL: prdata <= {23'h000000, while_q, until_q, back_q, size_q, xlt_q, op_q, 1'b0};
                    `SIE_OFS_STATUS: prdata <= {28'h0000000, why_q, done_q, busy};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Option and mode capture at start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= sie_pkg::SIE_OP_MOVE;
            size_q <= sie_pkg::SIE_SZ_BYTE;
            xlt_q <= 1'b0;
            back_q <= 1'b0;
            until_q <= 1'b0;
            while_q <= 1'b0;
        end else if (start) begin
            op_q <= sie_pkg::sie_op_type'(pwdata[`SIE_CTRL_OP_LSB +: 2]);
            xlt_q <= pwdata[`SIE_CTRL_XLT];
            // Translating forms are byte only
            size_q <= pwdata[`SIE_CTRL_XLT] ? sie_pkg::SIE_SZ_BYTE
                : sie_pkg::sie_size_type'(pwdata[`SIE_CTRL_SIZE_LSB +: 2]); // [R10]
            back_q <= pwdata[`SIE_CTRL_BACK]; // [R9]
            until_q <= pwdata[`SIE_CTRL_UNTIL]; // [R9]
            while_q <= pwdata[`SIE_CTRL_WHILE]; // [R9]
        end
    end

    // General registers: software writes when idle, the engine updates per step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_q <= `SIE_REG_RESET;
            str1_q <= `SIE_REG_RESET;
            str2_q <= `SIE_REG_RESET;
            table_q <= `SIE_REG_RESET;
            cmpval_q <= `SIE_REG_RESET;
        end else if (state_q == ST_STEP) begin
            limit_q <= limit_q - 32'h0000_0001; // [R2] [R11]
            str1_q <= back_q ? str1_q - step : str1_q + step; // [R3] [R11]
            if (op_q != sie_pkg::SIE_OP_SKIP) begin
                str2_q <= back_q ? str2_q - step : str2_q + step; // [R3] [R11]
            end
        end else if (wr_acc && !busy) begin
            case (paddr)
                `SIE_OFS_LIMIT: limit_q <= pwdata; // [R1]
                `SIE_OFS_STR1: str1_q <= pwdata; // [R1]
                `SIE_OFS_STR2: str2_q <= pwdata; // [R1]
                `SIE_OFS_TABLE: table_q <= pwdata; // [R1]
                `SIE_OFS_CMPVAL: cmpval_q <= pwdata; // [R1]
                default: ;
            endcase
        end
    end

    // Element sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            elem_q <= 32'h0000_0000;
            done_q <= 1'b0;
            why_q <= sie_pkg::SIE_END_COUNT;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        done_q <= 1'b0;
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (limit_q == 32'h0000_0000) begin
                        why_q <= sie_pkg::SIE_END_COUNT; // [R2]
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        req_q <= '{valid: 1'b1, write: 1'b0, addr: str1_q, wdata: 32'h0000_0000, size: size_q};
                        state_q <= ST_READ1;
                    end
                end
                ST_READ1: begin
                    if (mem_ack) begin
                        req_q.valid <= 1'b0;
                        elem_q <= rd_elem;
                        if (xlt_q) begin
                            // Table entry for this byte
                            req_q <= '{valid: 1'b1, write: 1'b0, addr: table_q + {24'h000000, mem_rdata[7:0]},
                                       wdata: 32'h0000_0000, size: sie_pkg::SIE_SZ_BYTE}; // [R6] [R7] [R8]
                            state_q <= ST_XLATE;
                        end else begin
                            state_q <= ST_TEST;
                        end
                    end
                end
                ST_XLATE: begin
                    if (mem_ack) begin
                        req_q.valid <= 1'b0;
                        elem_q <= {24'h000000, mem_rdata[7:0]};
                        state_q <= ST_TEST;
                    end
                end
                ST_TEST: begin
                    if (stop_match) begin
                        why_q <= sie_pkg::SIE_END_MATCH; // [R4] [R5] [R8]
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (fifo_in_ready) begin
                        state_q <= ST_POP;
                    end
                end
                ST_POP: begin
                    if (fifo_out_valid) begin
                        case (op_q)
                            sie_pkg::SIE_OP_MOVE: begin
                                req_q <= '{valid: 1'b1, write: 1'b1, addr: str2_q, wdata: fifo_out_data,
                                           size: size_q}; // [R6]
                                state_q <= ST_WRITE2;
                            end
                            sie_pkg::SIE_OP_COMPARE: begin
                                req_q <= '{valid: 1'b1, write: 1'b0, addr: str2_q, wdata: 32'h0000_0000,
                                           size: size_q}; // [R7]
                                state_q <= ST_READ2;
                            end
                            default: state_q <= ST_STEP; // [R8]
                        endcase
                    end
                end
                ST_WRITE2: begin
                    if (mem_ack) begin
                        req_q.valid <= 1'b0;
                        state_q <= ST_STEP;
                    end
                end
                ST_READ2: begin
                    if (mem_ack) begin
                        req_q.valid <= 1'b0;
                        // String 2 is never translated
                        if (rd_elem != cur_q) begin
                            why_q <= sie_pkg::SIE_END_DIFFER; // [R7]
                            done_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_STEP;
                        end
                    end
                end
                ST_STEP: state_q <= ST_CHECK;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Popped element held for the string 2 compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_q <= 32'h0000_0000;
        end else if (state_q == ST_POP && fifo_out_valid) begin
            cur_q <= fifo_out_data;
        end
    end

    sie_fifo #(
        .WIDTH(32),
        .DEPTH(`SIE_FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(state_q == ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(elem_q),
        .out_valid(fifo_out_valid),
        .out_ready(state_q == ST_POP),
        .out_data(fifo_out_data)
    );
endmodule : sie_engine

// ---- logic/sie_params.svh ----
// Offsets, fields and reset values of the string instruction engine.
// Assumes a 32-bit APB slave on pclk at 20 MHz with word-aligned registers.
// How it works
// R1: Five lowest general registers hold limit, two pointers, table pointer, comparison value.
// R2: Limit decrements each element step; any instruction ends when limit reaches zero.
// R3: Backward option decrements the string pointers per step, otherwise they increment; skip never steps string 2.
// R4: Until option ends the instruction when the string 1 element equals comparison value.
// R5: While option ends the instruction when the string 1 element differs from it.
// R6: Move copies string 1 to string 2; translating move maps bytes through the table.
// R7: Compare checks string 1 against string 2; translating form maps string 1 bytes only.
// R8: Skip advances over string 1 without writing; translating form maps before the test.
// R9: Backward, until and while options are accepted on every string operation.
// R10: Plain forms use byte, word or double size; translating forms use bytes only.
// R11: Pointers and limit are written back every step, showing the exact stop point.
`ifndef SIE_PARAMS_SVH
`define SIE_PARAMS_SVH
`define SIE_OFS_LIMIT 12'h000
`define SIE_OFS_STR1 12'h004
`define SIE_OFS_STR2 12'h008
`define SIE_OFS_TABLE 12'h00c
`define SIE_OFS_CMPVAL 12'h010
`define SIE_OFS_CTRL 12'h014
`define SIE_OFS_STATUS 12'h018
`define SIE_CTRL_START 0
`define SIE_CTRL_OP_LSB 1
`define SIE_CTRL_XLT 3
`define SIE_CTRL_SIZE_LSB 4
`define SIE_CTRL_BACK 6
`define SIE_CTRL_UNTIL 7
`define SIE_CTRL_WHILE 8
`define SIE_STAT_BUSY 0
`define SIE_STAT_DONE 1
`define SIE_STAT_WHY_LSB 2
`define SIE_FIFO_DEPTH 8
`define SIE_REG_RESET 32'h0000_0000
`endif

// ---- logic/sie_pkg.sv ----
// Types shared by the string instruction engine.
// Assumes sie_params.svh is included by the design file.
package sie_pkg;
    typedef enum logic [1:0] {
        SIE_OP_MOVE = 2'b00,
        SIE_OP_COMPARE = 2'b01,
        SIE_OP_SKIP = 2'b10
    } sie_op_type;
    typedef enum logic [1:0] {
        SIE_SZ_BYTE = 2'b00,
        SIE_SZ_WORD = 2'b01,
        SIE_SZ_DOUBLE = 2'b10
    } sie_size_type;
    typedef enum logic [1:0] {
        SIE_END_COUNT = 2'b00,
        SIE_END_MATCH = 2'b01,
        SIE_END_DIFFER = 2'b10
    } sie_end_type;
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0] size;
    } sie_mem_req_type;
endpackage : sie_pkg

// ---- dv/sie_engine_props.sv ----
// Assertions on the string engine's APB and memory ports.
// Assumes it is bound to sie_engine and sees a single clock domain.
`timescale 1ns/1ps
module sie_engine_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sie_pkg::sie_mem_req_type mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic busy
);
    logic wr_idle;
    logic go;
    logic [1:0] op_q;
    logic xlt_q;
    logic lim0_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_idle = psel && penable && pwrite && !busy;
    assign go = wr_idle && paddr == 12'h014 && pwdata[0];
    // Options of the running instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= 2'h0;
            xlt_q <= 1'b0;
        end else if (go) begin
            op_q <= pwdata[2:1];
            xlt_q <= pwdata[3];
        end
    end
    // Limit known to be zero only until the engine runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim0_q <= 1'b1;
        end else if (busy) begin
            lim0_q <= 1'b0;
        end else if (wr_idle && paddr == 12'h000) begin
            lim0_q <= pwdata == 32'h0;
        end
    end
    a_req_hold: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
        else $error("memory request changed before acknowledge");
    a_req_busy: assert property (mem_req.valid |-> busy)
        else $error("memory request while idle");
    a_start_busy: assert property (go |=> busy)
        else $error("start did not raise busy");
    a_xlt_byte: assert property (busy && xlt_q && mem_req.valid |-> mem_req.size == 2'h0)
        else $error("translating access not byte sized");
    a_skip_read: assert property (busy && op_q == 2'h2 && mem_req.valid |-> !mem_req.write)
        else $error("skip wrote memory");
    a_cmp_read: assert property (busy && op_q == 2'h1 && mem_req.valid |-> !mem_req.write)
        else $error("compare wrote memory");
    a_bad_addr: assert property (psel && !penable && (paddr > 12'h018 || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access without error");
    a_good_addr: assert property (psel && !penable && paddr <= 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access flagged as error");
    a_limit_zero: assert property (go && lim0_q |=> !mem_req.valid [*4])
        else $error("memory touched with zero limit");
    cover property (go && pwdata[7]);
    cover property (pslverr);
    cover property (mem_ack && mem_req.write);
endmodule : sie_engine_props

bind sie_engine sie_engine_props sie_engine_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));

// ---- dv/sie_mem_model.sv ----
// Byte-addressed memory answering the engine's element requests.
// Assumes requests are held until mem_ack; delay sets wait cycles per answer.
`timescale 1ns/1ps
module sie_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire sie_pkg::sie_mem_req_type mem_req,
    input wire logic [1:0] delay,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [7:0] mem [0:511];
    logic [1:0] wait_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q <= 2'h0;
            mem_rdata <= 32'h5a5a_c3c3;
        end else begin
            mem_ack <= 1'b0;
            // Data toggles outside an answer so a stale value is never trusted
            mem_rdata <= ~mem_rdata;
            if (mem_req.valid && !mem_ack && wait_q != delay) begin
                wait_q <= wait_q + 2'h1;
            end else if (mem_req.valid && !mem_ack) begin
                wait_q <= 2'h0;
                mem_ack <= 1'b1;
                for (int k = 0; k < 4; k++) begin
                    mem_rdata[8*k+:8] <= mem[mem_req.addr[8:0] + 9'(k)];
                    if (mem_req.write && k < (1 << mem_req.size)) begin
                        mem[mem_req.addr[8:0] + 9'(k)] <= mem_req.wdata[8*k+:8];
                    end
                end
            end
        end
    end
endmodule : sie_mem_model

// ---- dv/sie_engine_tb_top.sv ----
// Self-checking bench driving sie_engine over APB against a memory model.
// Assumes strings sit low in the model and the table at 0x100 holds i+1.
`timescale 1ns/1ps
`include "sie_params.svh"
module sie_engine_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_rdata, rd;
    logic [1:0] delay;
    sie_pkg::sie_mem_req_type mem_req;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    sie_engine sie_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
    sie_mem_model sie_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .delay(delay),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic start(input logic [31:0] lim, s1, s2, cv, c);
        xfer(1'b1, `SIE_OFS_LIMIT, lim);
        xfer(1'b1, `SIE_OFS_STR1, s1);
        xfer(1'b1, `SIE_OFS_STR2, s2);
        xfer(1'b1, `SIE_OFS_CMPVAL, cv);
        xfer(1'b1, `SIE_OFS_CTRL, c);
    endtask : start
    task automatic stop(input logic [31:0] lim, s1, s2, input logic [1:0] why);
        do xfer(1'b0, `SIE_OFS_STATUS, 32'h0); while (rd[`SIE_STAT_BUSY] !== 1'b0);
        rchk(`SIE_OFS_LIMIT, lim);
        rchk(`SIE_OFS_STR1, s1);
        rchk(`SIE_OFS_STR2, s2);
        rchk(`SIE_OFS_STATUS, {28'h0, why, 2'b10});
        chk({31'h0, busy}, 32'h0);
    endtask : stop
    function automatic logic [31:0] ctl(input logic [1:0] op, input logic x, input logic [1:0] sz,
        input logic [2:0] opt);
        return {23'h0, opt, sz, x, op, 1'b1};
    endfunction : ctl
    task automatic put(input logic [8:0] a, input logic [31:0] v);
        for (int k = 0; k < 4; k++) begin
            sie_mem_model_i.mem[a + 9'(k)] = v[8*k+:8];
        end
    endtask : put
    function automatic logic [31:0] peek(input logic [8:0] a);
        return {sie_mem_model_i.mem[a + 9'h3], sie_mem_model_i.mem[a + 9'h2],
            sie_mem_model_i.mem[a + 9'h1], sie_mem_model_i.mem[a]};
    endfunction : peek
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, delay} = '0;
        for (int i = 0; i < 512; i++) begin
            sie_mem_model_i.mem[i] = (i < 256) ? 8'hee : 8'(i - 255);
        end
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`SIE_OFS_LIMIT, 32'h0);
        rchk(`SIE_OFS_STATUS, 32'h0);
        xfer(1'b0, 12'h01c, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, `SIE_OFS_TABLE, 32'h100);
        chk({31'h0, err}, 32'h0);
        rchk(`SIE_OFS_TABLE, 32'h100);
        // Slow memory; the limit write lands while busy and must be ignored
        delay <= 2'h2;
        put(9'h010, 32'h0033_3231);
        start(32'h3, 32'h10, 32'h40, 32'h0, ctl(sie_pkg::SIE_OP_MOVE, 1'b0, 2'h0, 3'b000));
        xfer(1'b1, `SIE_OFS_LIMIT, 32'h77);
        chk({31'h0, busy}, 32'h1);
        stop(32'h0, 32'h13, 32'h43, 2'h0);
        chk(peek(9'h040), 32'hee33_3231);
        delay <= 2'h1;
        put(9'h020, 32'h0000_0605);
        start(32'h2, 32'h21, 32'h61, 32'h0, ctl(sie_pkg::SIE_OP_MOVE, 1'b1, 2'h2, 3'b001));
        stop(32'h0, 32'h1f, 32'h5f, 2'h0);
        chk(peek(9'h05f), 32'hee07_06ee);
        // Translating start forces byte size: backward and translate bits only
        rchk(`SIE_OFS_CTRL, 32'h0000_0048);
        delay <= 2'h0;
        put(9'h010, 32'h0403_0201);
        start(32'h8, 32'h10, 32'h99, 32'h3, ctl(sie_pkg::SIE_OP_SKIP, 1'b0, 2'h0, 3'b010));
        stop(32'h6, 32'h12, 32'h99, 2'h1);
        put(9'h010, 32'h0005_0404);
        start(32'h8, 32'h10, 32'h99, 32'h5, ctl(sie_pkg::SIE_OP_SKIP, 1'b1, 2'h0, 3'b100));
        stop(32'h6, 32'h12, 32'h99, 2'h1);
        start(32'h4, 32'h10, 32'h80, 32'h5, ctl(sie_pkg::SIE_OP_MOVE, 1'b0, 2'h0, 3'b010));
        stop(32'h2, 32'h12, 32'h82, 2'h1);
        chk(peek(9'h080), 32'heeee_0404);
        put(9'h030, 32'h4433_2211);
        put(9'h050, 32'h4533_2211);
        start(32'h3, 32'h30, 32'h50, 32'h0, ctl(sie_pkg::SIE_OP_COMPARE, 1'b0, 2'h1, 3'b000));
        stop(32'h2, 32'h32, 32'h52, 2'h2);
        put(9'h054, 32'h0000_0005);
        start(32'h1, 32'h10, 32'h54, 32'h0, ctl(sie_pkg::SIE_OP_COMPARE, 1'b1, 2'h0, 3'b000));
        stop(32'h0, 32'h11, 32'h55, 2'h0);
        start(32'h1, 32'h30, 32'h70, 32'h0, ctl(sie_pkg::SIE_OP_MOVE, 1'b0, 2'h2, 3'b000));
        stop(32'h0, 32'h34, 32'h74, 2'h0);
        chk(peek(9'h070), 32'h4433_2211);
        start(32'h0, 32'h30, 32'h78, 32'h0, ctl(sie_pkg::SIE_OP_MOVE, 1'b0, 2'h2, 3'b101));
        stop(32'h0, 32'h30, 32'h78, 2'h0);
        chk(peek(9'h078), 32'heeee_eeee);
        close_out();
    end
endmodule : sie_engine_tb_top
